// ### design/cpsq_pkg.sv
// shared constants and carrier types for the cell protection sequencer
package cpsq_pkg;

    // core clock and the internal delay tick
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam int PRE_W = 6;

    // delay counter structure
    localparam int CNT_W = 21;
    localparam int NCH = 5;
    localparam int CH_OVCHG = 0;
    localparam int CH_OVDIS = 1;
    localparam int CH_OVCUR = 2;
    localparam int CH_SHORT = 3;
    localparam int CH_EXCESS = 4;

    // test mode divides counter delays other than the short delay by two to this power
    localparam int TEST_SHIFT = 6;

    // nominal delays in their own units
    localparam real OVCHG_DET_S = 1.0;
    localparam real OVCHG_REL_MS = 40.0;
    localparam real OVDIS_DET_MS = 100.0;
    localparam real OVDIS_REL_MS = 1.0;
    localparam real OVCUR_DET_MS = 20.0;
    localparam real OVCUR_REL_MS = 1.0;
    localparam real SHORT_DET_MS = 0.250;
    localparam real EXCESS_DET_MS = 1.5;
    localparam real EXCESS_REL_MS = 1.5;

    // the same delays in ticks
    localparam int OVCHG_DET_TICKS = int'(OVCHG_DET_S * 1.0e9 / TICK_NS);
    localparam int OVCHG_REL_TICKS = int'(OVCHG_REL_MS * 1.0e6 / TICK_NS);
    localparam int OVDIS_DET_TICKS = int'(OVDIS_DET_MS * 1.0e6 / TICK_NS);
    localparam int OVDIS_REL_TICKS = int'(OVDIS_REL_MS * 1.0e6 / TICK_NS);
    localparam int OVCUR_DET_TICKS = int'(OVCUR_DET_MS * 1.0e6 / TICK_NS);
    localparam int OVCUR_REL_TICKS = int'(OVCUR_REL_MS * 1.0e6 / TICK_NS);
    localparam int SHORT_DET_TICKS = int'(SHORT_DET_MS * 1.0e6 / TICK_NS);
    localparam int EXCESS_DET_TICKS = int'(EXCESS_DET_MS * 1.0e6 / TICK_NS);
    localparam int EXCESS_REL_TICKS = int'(EXCESS_REL_MS * 1.0e6 / TICK_NS);

    typedef enum logic {
        MODE_RUN,
        MODE_STBY
    } cpsq_mode_t;

    // comparator flags, all synchronous to core_clk
    typedef struct packed {
        logic ovchg_det;
        logic ovchg_rel;
        logic ovdis_det;
        logic ovdis_rel;
        logic ovcur_det;
        logic short_det;
        logic excess_det;
        logic stby_release;
        logic load_present;
    } cpsq_cmp_t;

    typedef struct packed {
        logic charge_sw_on;
        logic discharge_sw_on;
        logic pull_up_en;
        logic pull_down_en;
        logic small_hyst_sel;
        logic monitor_en;
        logic standby;
    } cpsq_out_t;

    localparam cpsq_out_t OUT_RST = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

endpackage : cpsq_pkg

// ### design/cpsq_sequencer.sv
// cell protection sequencer: delay timing and switch control
`timescale 1ns/100ps
module cpsq_sequencer #(
    parameter int unsigned OVCHG_DET_TICKS = cpsq_pkg::OVCHG_DET_TICKS,
    parameter int unsigned OVCHG_REL_TICKS = cpsq_pkg::OVCHG_REL_TICKS,
    parameter int unsigned OVDIS_DET_TICKS = cpsq_pkg::OVDIS_DET_TICKS,
    parameter int unsigned OVCUR_DET_TICKS = cpsq_pkg::OVCUR_DET_TICKS
) (
    // clock, reset and enable
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // comparator flags and test pin
    input wire cpsq_pkg::cpsq_cmp_t cmp,
    input wire logic delay_shorten,
    // switch and resistor controls
    output cpsq_pkg::cpsq_out_t ctl
);

    localparam int CW = cpsq_pkg::CNT_W;
    localparam logic [CW-1:0] T_OVCHG_DET = CW'(OVCHG_DET_TICKS);
    localparam logic [CW-1:0] T_OVCHG_REL = CW'(OVCHG_REL_TICKS);
    localparam logic [CW-1:0] T_OVDIS_DET = CW'(OVDIS_DET_TICKS);
    localparam logic [CW-1:0] T_OVDIS_REL = CW'(cpsq_pkg::OVDIS_REL_TICKS);
    localparam logic [CW-1:0] T_OVCUR_DET = CW'(OVCUR_DET_TICKS);
    localparam logic [CW-1:0] T_OVCUR_REL = CW'(cpsq_pkg::OVCUR_REL_TICKS);
    localparam logic [CW-1:0] T_SHORT_DET = CW'(cpsq_pkg::SHORT_DET_TICKS);
    localparam logic [CW-1:0] T_EXCESS_DET = CW'(cpsq_pkg::EXCESS_DET_TICKS);
    localparam logic [CW-1:0] T_EXCESS_REL = CW'(cpsq_pkg::EXCESS_REL_TICKS);
    localparam int PW = cpsq_pkg::PRE_W;
    localparam logic [PW-1:0] PRE_LAST = PW'(cpsq_pkg::TICK_CYC - 1);

    logic [cpsq_pkg::PRE_W-1:0] pre_q;
    logic tick_q;
    logic [CW-1:0] cnt_q [cpsq_pkg::NCH];
    logic [CW-1:0] tgt [cpsq_pkg::NCH];
    logic [cpsq_pkg::NCH-1:0] cond;
    logic [cpsq_pkg::NCH-1:0] done;
    logic ovchg_q;
    logic ovdis_q;
    logic ocs_q;
    logic ex_q;
    logic small_hyst_q;
    cpsq_pkg::cpsq_mode_t mode_q;
    logic run;
    logic ovchg_rel_ok;

    // test mode shortens a counter delay, never below one tick
    function automatic logic [CW-1:0] shorten_f(input logic [CW-1:0] n, input logic en);
        logic [CW-1:0] s;
        s = n >> cpsq_pkg::TEST_SHIFT;
        if (!en) begin
            return n;
        end
        return (s == '0) ? CW'(1) : s;
    endfunction : shorten_f

    // delay tick prescaler
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_q <= '0;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            tick_q <= (pre_q == PRE_LAST);
            pre_q <= (pre_q == PRE_LAST) ? '0 : pre_q + 1'b1;
        end
    end

    assign run = (mode_q == cpsq_pkg::MODE_RUN);
    // load-sense high without a load blocks release
    assign ovchg_rel_ok = cmp.ovchg_rel && (!cmp.ovcur_det || cmp.load_present);

    // count conditions: detection while idle, release while held; the short channel only detects
    always_comb begin
        cond = '0;
        cond[cpsq_pkg::CH_OVCHG] = ovchg_q ? (run && ovchg_rel_ok) : (run && cmp.ovchg_det);
        cond[cpsq_pkg::CH_OVDIS] = ovdis_q ? (run && cmp.ovdis_rel) : (run && cmp.ovdis_det);
        cond[cpsq_pkg::CH_OVCUR] = ocs_q ? !cmp.ovcur_det : (!ovchg_q && cmp.ovcur_det);
        cond[cpsq_pkg::CH_SHORT] = !ocs_q && cmp.short_det;
        cond[cpsq_pkg::CH_EXCESS] = ex_q ? !cmp.excess_det
            : (cmp.excess_det && !ovdis_q && !ocs_q);
    end

    // targets; the short delay bypasses the test shortening
    always_comb begin
        tgt[cpsq_pkg::CH_OVCHG] = shorten_f(ovchg_q ? T_OVCHG_REL : T_OVCHG_DET, delay_shorten);
        tgt[cpsq_pkg::CH_OVDIS] = shorten_f(ovdis_q ? T_OVDIS_REL : T_OVDIS_DET, delay_shorten);
        tgt[cpsq_pkg::CH_OVCUR] = shorten_f(ocs_q ? T_OVCUR_REL : T_OVCUR_DET, delay_shorten);
        tgt[cpsq_pkg::CH_SHORT] = T_SHORT_DET;
        tgt[cpsq_pkg::CH_EXCESS] = shorten_f(ex_q ? T_EXCESS_REL : T_EXCESS_DET,
            delay_shorten);
    end

    // one delay counter per channel
    for (genvar i = 0; i < cpsq_pkg::NCH; i++) begin : g_tmr
        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                cnt_q[i] <= '0;
            end else if (clk_en) begin
                if (!cond[i] || done[i]) begin
                    cnt_q[i] <= '0;
                end else if (tick_q) begin
                    cnt_q[i] <= cnt_q[i] + 1'b1;
                end
            end
        end
        assign done[i] = clk_en && cond[i] && tick_q && (cnt_q[i] == tgt[i] - 1'b1);
    end

    // over-charge hold
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ovchg_q <= 1'b0;
        end else if (clk_en && done[cpsq_pkg::CH_OVCHG]) begin
            ovchg_q <= !ovchg_q;
        end
    end

    // small hysteresis once a load appears after over-charge
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            small_hyst_q <= 1'b0;
        end else if (clk_en) begin
            if (!ovchg_q) begin
                small_hyst_q <= 1'b0;
            end else if (cmp.load_present) begin
                small_hyst_q <= 1'b1;
            end
        end
    end

    // over-discharge hold
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ovdis_q <= 1'b0;
        end else if (clk_en && done[cpsq_pkg::CH_OVDIS]) begin
            ovdis_q <= !ovdis_q;
        end
    end

    // stand-by; not entered when over-charge already holds
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= cpsq_pkg::MODE_RUN;
        end else if (clk_en) begin
            case (mode_q)
                cpsq_pkg::MODE_RUN: begin
                    if (done[cpsq_pkg::CH_OVDIS] && !ovdis_q && !ovchg_q) begin
                        mode_q <= cpsq_pkg::MODE_STBY;
                    end
                end
                cpsq_pkg::MODE_STBY: begin
                    if (cmp.stby_release) begin
                        mode_q <= cpsq_pkg::MODE_RUN;
                    end
                end
                default: begin
                    mode_q <= cpsq_pkg::MODE_RUN;
                end
            endcase
        end
    end

    // over-current or short hold; either trip enters it
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ocs_q <= 1'b0;
        end else if (clk_en) begin
            if (!ocs_q && (done[cpsq_pkg::CH_OVCUR] || done[cpsq_pkg::CH_SHORT])) begin
                ocs_q <= 1'b1;
            end else if (ocs_q && done[cpsq_pkg::CH_OVCUR]) begin
                ocs_q <= 1'b0;
            end
        end
    end

    // excessive charger hold
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ex_q <= 1'b0;
        end else if (clk_en && done[cpsq_pkg::CH_EXCESS]) begin
            ex_q <= !ex_q;
        end
    end

    // registered pin controls
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl <= cpsq_pkg::OUT_RST;
        end else if (clk_en) begin
            ctl.charge_sw_on <= !(ovchg_q || ex_q);
            ctl.discharge_sw_on <= !(ovdis_q || ocs_q);
            ctl.pull_up_en <= ovdis_q;
            ctl.pull_down_en <= ocs_q;
            ctl.small_hyst_sel <= small_hyst_q && ovchg_q;
            ctl.monitor_en <= run;
            ctl.standby <= !run;
        end
    end

    // checks
    property p_chg_low;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && (ovchg_q || ex_q)) |=> !ctl.charge_sw_on;
    endproperty
    a_chg_low: assert property (p_chg_low) else $error("charge switch not low");

    property p_no_ovcur_after_ovchg;
        @(posedge core_clk) disable iff (!reset_n)
        (ovchg_q && !ocs_q) |-> !cond[cpsq_pkg::CH_OVCUR];
    endproperty
    a_no_ovcur_after_ovchg: assert property (p_no_ovcur_after_ovchg)
        else $error("over-current counted during over-charge");

    property p_short_delay_fixed;
        @(posedge core_clk) disable iff (!reset_n)
        delay_shorten |-> tgt[cpsq_pkg::CH_SHORT] == T_SHORT_DET;
    endproperty
    a_short_delay_fixed: assert property (p_short_delay_fixed)
        else $error("short delay was shortened");

    property p_shorten;
        @(posedge core_clk) disable iff (!reset_n)
        (delay_shorten && !ovchg_q) |-> tgt[cpsq_pkg::CH_OVCHG] < T_OVCHG_DET;
    endproperty
    a_shorten: assert property (p_shorten) else $error("test mode not shortening");

    property p_pull_down;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && ocs_q) |=> (ctl.pull_down_en && !ctl.discharge_sw_on);
    endproperty
    a_pull_down: assert property (p_pull_down) else $error("pull-down not enabled");

    property p_pull_up;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && ovdis_q) |=> ctl.pull_up_en;
    endproperty
    a_pull_up: assert property (p_pull_up) else $error("pull-up not enabled");

    property p_no_excess_in_ovdis;
        @(posedge core_clk) disable iff (!reset_n)
        (ovdis_q && !ex_q) |-> cnt_q[cpsq_pkg::CH_EXCESS] == '0;
    endproperty
    a_no_excess_in_ovdis: assert property (p_no_excess_in_ovdis)
        else $error("excess count during over-discharge");

    property p_abandon;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && !cond[cpsq_pkg::CH_OVCHG]) |=> (cnt_q[cpsq_pkg::CH_OVCHG] == '0) &&
            $stable(ovchg_q);
    endproperty
    a_abandon: assert property (p_abandon) else $error("count not abandoned");

    property p_wake;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && !run && cmp.stby_release) |=> run ##1 ctl.monitor_en;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake from stand-by");

    property p_hold_low;
        @(posedge core_clk) disable iff (!reset_n)
        (ovchg_q && cmp.ovcur_det && cmp.load_present && !cmp.ovchg_rel) |->
            !done[cpsq_pkg::CH_OVCHG];
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("charge released too early");

    property p_tick_period;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && tick_q) |=> !tick_q;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick lasts too long");

    property p_dis_low;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && (ovdis_q || ocs_q)) |=> !ctl.discharge_sw_on;
    endproperty
    a_dis_low: assert property (p_dis_low) else $error("discharge switch not low");

    property p_stby_entry;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && run && !ovdis_q && !ovchg_q && done[cpsq_pkg::CH_OVDIS]) |=>
            (ovdis_q && !run);
    endproperty
    a_stby_entry: assert property (p_stby_entry) else $error("stand-by not entered");

    property p_stby_outputs;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && !run) |=> (ctl.standby && !ctl.monitor_en);
    endproperty
    a_stby_outputs: assert property (p_stby_outputs) else $error("monitoring left on");

    property p_hyst_clear;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && !ovchg_q) |=> !ctl.small_hyst_sel;
    endproperty
    a_hyst_clear: assert property (p_hyst_clear) else $error("small hysteresis kept");

    property p_chg_release;
        @(posedge core_clk) disable iff (!reset_n)
        (ovchg_q && !ex_q && done[cpsq_pkg::CH_OVCHG] && !done[cpsq_pkg::CH_EXCESS])
            ##1 clk_en |=> ctl.charge_sw_on;
    endproperty
    a_chg_release: assert property (p_chg_release)
        else $error("charge switch not released");

    property p_dis_release;
        @(posedge core_clk) disable iff (!reset_n)
        (ovdis_q && !ocs_q && done[cpsq_pkg::CH_OVDIS] && !done[cpsq_pkg::CH_SHORT] &&
            !done[cpsq_pkg::CH_OVCUR]) ##1 clk_en |=> ctl.discharge_sw_on;
    endproperty
    a_dis_release: assert property (p_dis_release)
        else $error("discharge switch not released");

    property p_short_hold;
        @(posedge core_clk) disable iff (!reset_n)
        (!ocs_q && done[cpsq_pkg::CH_SHORT]) ##1 clk_en |=> ctl.pull_down_en;
    endproperty
    a_short_hold: assert property (p_short_hold) else $error("short not held");

    c_ovchg: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(ovchg_q));
    c_standby: cover property (@(posedge core_clk) disable iff (!reset_n) $fell(run));
    c_short: cover property (@(posedge core_clk) disable iff (!reset_n)
        $rose(ocs_q) && done[cpsq_pkg::CH_SHORT]);
    c_excess: cover property (@(posedge core_clk) disable iff (!reset_n) $fell(ex_q));
    c_wake: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(run));

endmodule : cpsq_sequencer

// ### verification/cpsq_far_side.sv
// far-side model: two cells, a load and a charger seen through comparator flags
`timescale 1ns/100ps
module cpsq_far_side (
    // cell voltages in millivolts
    input wire logic [15:0] cell0_mv,
    input wire logic [15:0] cell1_mv,
    // load: 0 none, 1 normal, 2 over-current, 3 short
    input wire logic [1:0] load_level,
    // charger: 0 none, 1 normal, 2 excessive voltage
    input wire logic [1:0] charger_level,
    // switch controls and flags
    input wire cpsq_pkg::cpsq_out_t ctl,
    output cpsq_pkg::cpsq_cmp_t cmp
);
    localparam logic [15:0] OVCHG_MV = 16'h10fe;
    localparam logic [15:0] REL_MV = 16'h1036;
    localparam logic [15:0] OVDIS_MV = 16'h08fc;

    always_comb begin
        cmp.ovchg_det = (cell0_mv >= OVCHG_MV) || (cell1_mv >= OVCHG_MV);
        cmp.ovchg_rel = (cell0_mv <= REL_MV) && (cell1_mv <= REL_MV);
        cmp.ovdis_det = (cell0_mv <= OVDIS_MV) || (cell1_mv <= OVDIS_MV);
        cmp.ovdis_rel = (cell0_mv >= OVDIS_MV) && (cell1_mv >= OVDIS_MV);
        // an over-current or short load keeps the node high even with the switch off
        cmp.ovcur_det = load_level >= 2'h2;
        cmp.short_det = load_level == 2'h3;
        // flag stays up with discharge off; blocking it is the device's job
        cmp.excess_det = charger_level == 2'h2;
        cmp.stby_release = charger_level != 2'h0;
        cmp.load_present = load_level != 2'h0;
    end
endmodule : cpsq_far_side

// ### verification/testbench.sv
// self-checking bench for the cell protection sequencer
`timescale 1ns/100ps
module testbench;
    localparam int P_OCH = 640;
    localparam int P_OCR = 320;
    localparam int P_ODD = 448;
    localparam int P_OCD = 384;
    localparam int LIMIT = 60000;

    typedef struct {
        cpsq_pkg::cpsq_out_t val;
        int lo;
        int hi;
    } cpsq_note_t;

    logic core_clk;
    logic reset_n;
    logic clk_en;
    logic delay_shorten;
    cpsq_pkg::cpsq_cmp_t cmp;
    cpsq_pkg::cpsq_out_t ctl;
    cpsq_pkg::cpsq_out_t e;
    cpsq_pkg::cpsq_out_t prev;
    logic [15:0] cell0_mv;
    logic [15:0] cell1_mv;
    logic [1:0] load_level;
    logic [1:0] charger_level;
    int cyc = 0;
    int bad_count = 0;
    int total_checks = 0;
    int seed;
    cpsq_note_t exp_q[$];
    cpsq_note_t note;

    cpsq_sequencer #(.OVCHG_DET_TICKS(P_OCH), .OVCHG_REL_TICKS(P_OCR),
        .OVDIS_DET_TICKS(P_ODD), .OVCUR_DET_TICKS(P_OCD)) cpsq_sequencer_inst (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .cmp(cmp),
        .delay_shorten(delay_shorten), .ctl(ctl));

    cpsq_far_side cpsq_far_side_inst (.cell0_mv(cell0_mv), .cell1_mv(cell1_mv),
        .load_level(load_level), .charger_level(charger_level), .ctl(ctl), .cmp(cmp));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic results();
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, want, seen);
        end
    endtask : check

    // shortened form keeps at least one tick
    function automatic int dly(input int n);
        if (delay_shorten === 1'b0) return n;
        return ((n >> 6) == 0) ? 1 : (n >> 6);
    endfunction : dly

    // healthy cell between release and over-discharge levels
    function automatic logic [15:0] rand_cell();
        return 16'(3000 + ({$random(seed)} % 1000));
    endfunction : rand_cell

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask : step

    // tick phase gives one tick of slack early and six cycles late
    task automatic expect_ctl(input int ticks);
        int lo;
        int hi;
        lo = (ticks == 0) ? 0 : (ticks - 1) * 40;
        hi = ticks * 40 + 6;
        exp_q.push_back('{e, cyc + lo, cyc + hi});
        repeat (hi + 8) begin
            if (exp_q.size() == 0) break;
            @(posedge core_clk);
        end
        check("pending notes", exp_q.size(), 0);
    endtask : expect_ctl

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            results();
        end
    end

    always @(posedge core_clk) begin
        if (reset_n === 1'b1 && ctl !== prev) begin
            if (exp_q.size() == 0) begin
                check("unexpected ctl", ctl, prev);
            end else begin
                note = exp_q.pop_front();
                check("ctl", ctl, note.val);
                check("ctl timing", (cyc >= note.lo) && (cyc <= note.hi), 1'b1);
            end
        end
        prev <= ctl;
    end

    initial begin
        seed = 25380;
        reset_n = 1'b0;
        clk_en = 1'b1;
        delay_shorten = 1'b1;
        cell0_mv = rand_cell();
        cell1_mv = rand_cell();
        load_level = 2'h0;
        charger_level = 2'h0;
        e = cpsq_pkg::OUT_RST;
        step(10);
        reset_n <= 1'b1;
        step(2);
        check("reset ctl", ctl, cpsq_pkg::OUT_RST);
        // over-charge dropped two ticks short must leave charge on
        cell0_mv <= 16'h1130;
        step((dly(P_OCH) - 2) * 40);
        cell0_mv <= rand_cell();
        step(80);
        cell0_mv <= 16'h1130;
        e.charge_sw_on = 1'b0;
        expect_ctl(dly(P_OCH));
        step(1);
        load_level <= 2'h2;
        e.small_hyst_sel = 1'b1;
        expect_ctl(0);
        // short still trips while over-current is held off; never shortened
        load_level <= 2'h3;
        e.discharge_sw_on = 1'b0;
        e.pull_down_en = 1'b1;
        expect_ctl(250);
        step(1);
        load_level <= 2'h1;
        e.discharge_sw_on = 1'b1;
        e.pull_down_en = 1'b0;
        expect_ctl(dly(1000));
        // over-current held off; cell above release keeps charge off
        load_level <= 2'h2;
        cell0_mv <= 16'h1068;
        step((dly(P_OCD) + 3) * 40);
        cell0_mv <= 16'h0fa0;
        e.charge_sw_on = 1'b1;
        e.small_hyst_sel = 1'b0;
        expect_ctl(dly(P_OCR));
        e.discharge_sw_on = 1'b0;
        e.pull_down_en = 1'b1;
        expect_ctl(dly(P_OCD));
        step(1);
        load_level <= 2'h0;
        e.discharge_sw_on = 1'b1;
        e.pull_down_en = 1'b0;
        expect_ctl(dly(1000));
        // over-discharge, stand-by and charger wake-up
        step(1);
        cell1_mv <= 16'h0898;
        e.discharge_sw_on = 1'b0;
        e.pull_up_en = 1'b1;
        e.monitor_en = 1'b0;
        e.standby = 1'b1;
        expect_ctl(dly(P_ODD));
        cell1_mv <= 16'h0bb8;
        step(30 * 40);
        charger_level <= 2'h2;
        e.monitor_en = 1'b1;
        e.standby = 1'b0;
        expect_ctl(0);
        e.discharge_sw_on = 1'b1;
        e.pull_up_en = 1'b0;
        expect_ctl(dly(1000));
        e.charge_sw_on = 1'b0;
        expect_ctl(dly(1500));
        step(1);
        charger_level <= 2'h0;
        // a frozen clock enable must hold the release count back
        clk_en <= 1'b0;
        step(400);
        clk_en <= 1'b1;
        e.charge_sw_on = 1'b1;
        expect_ctl(dly(1500));
        // normal-length over-current detection
        step(1);
        delay_shorten <= 1'b0;
        step(1);
        load_level <= 2'h2;
        e.discharge_sw_on = 1'b0;
        e.pull_down_en = 1'b1;
        expect_ctl(dly(P_OCD));
        delay_shorten <= 1'b1;
        step(1);
        load_level <= 2'h0;
        e.discharge_sw_on = 1'b1;
        e.pull_down_en = 1'b0;
        expect_ctl(dly(1000));
        step(20);
        results();
    end
endmodule : testbench
